// ---- rtl/pscc_pkg.sv ----
// pscc_pkg: constants, types and helpers for the package sleep-state config block
// assumes one instance of the block per core, all logic on mclk
package pscc_pkg;

    // ----------------------------------------
    // register address and field layout
    // ----------------------------------------
    localparam logic [31:0] PSCC_CFG_ADDR = 32'h000000E2;
    localparam int PSCC_LIMIT_LSB = 0;
    localparam int PSCC_LIMIT_MSB = 2;
    localparam int PSCC_IOREDIR_BIT = 10;
    localparam int PSCC_LOCK_BIT = 15;
    localparam int PSCC_C3AD_BIT = 25;
    localparam int PSCC_C1AD_BIT = 26;
    localparam int PSCC_C3UN_BIT = 27;
    localparam int PSCC_C1UN_BIT = 28;
    localparam logic [63:0] PSCC_RD_MASK = 64'h000000001E008407;
    localparam logic [63:0] PSCC_RST_VALUE = 64'h0000000000000000;

    // ----------------------------------------
    // package limit and redirect range encodings
    // ----------------------------------------
    localparam logic [2:0] PSCC_LIM_C1 = 3'h0;
    localparam logic [2:0] PSCC_LIM_C2 = 3'h1;
    localparam logic [2:0] PSCC_LIM_C6N = 3'h2;
    localparam logic [2:0] PSCC_LIM_C6R = 3'h3;
    localparam logic [2:0] PSCC_LIM_C7 = 3'h4;
    localparam logic [2:0] PSCC_LIM_C7S = 3'h5;
    localparam logic [2:0] PSCC_LIM_NONE = 3'h7;
    localparam logic [2:0] PSCC_RNG_C3 = 3'h0;
    localparam logic [2:0] PSCC_RNG_C6 = 3'h1;
    localparam logic [2:0] PSCC_RNG_C7 = 3'h2;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        PSCC_C0 = 3'h0, PSCC_C1 = 3'h1, PSCC_C2 = 3'h2, PSCC_C3 = 3'h3,
        PSCC_C6N = 3'h4, PSCC_C6R = 3'h5, PSCC_C7 = 3'h6, PSCC_C7S = 3'h7
    } pscc_cstate_t;

    typedef enum logic [1:0] {
        PSCC_IDLE = 2'h0, PSCC_ACTIVE = 2'h1, PSCC_DEM_C3 = 2'h2, PSCC_DEM_C1 = 2'h3
    } pscc_phase_t;

    typedef struct packed {
        logic c1_undemote;
        logic c3_undemote;
        logic c1_autodemote;
        logic c3_autodemote;
        logic lock;
        logic io_redirect;
        logic [2:0] pkg_limit;
    } pscc_cfg_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [63:0] wdata;
    } pscc_msr_req_t;

    typedef struct packed {
        logic ack;
        logic fault;
        logic [63:0] rdata;
    } pscc_msr_rsp_t;

    typedef struct packed {
        pscc_cfg_t cfg;
        pscc_msr_rsp_t rsp;
        pscc_phase_t phase;
        pscc_cstate_t orig;
        logic grant_valid;
        pscc_cstate_t grant_state;
        pscc_cstate_t pkg_max;
        logic pkg_unlimited;
    } pscc_state_t;

    typedef struct packed {
        logic wfe_valid;
        pscc_cstate_t wfe_state;
    } pscc_redir_t;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [63:0] pscc_pack(input pscc_cfg_t c);
        logic [63:0] v;
        v = PSCC_RST_VALUE;
        v[PSCC_LIMIT_MSB:PSCC_LIMIT_LSB] = c.pkg_limit;
        v[PSCC_IOREDIR_BIT] = c.io_redirect;
        v[PSCC_LOCK_BIT] = c.lock;
        v[PSCC_C3AD_BIT] = c.c3_autodemote;
        v[PSCC_C1AD_BIT] = c.c1_autodemote;
        v[PSCC_C3UN_BIT] = c.c3_undemote;
        v[PSCC_C1UN_BIT] = c.c1_undemote;
        return v & PSCC_RD_MASK;
    endfunction : pscc_pack

    function automatic pscc_cstate_t pscc_limit_state(input logic [2:0] lim);
        pscc_cstate_t r;
        case (lim)
            PSCC_LIM_C1: r = PSCC_C1;
            PSCC_LIM_C2: r = PSCC_C2;
            PSCC_LIM_C6N: r = PSCC_C6N;
            PSCC_LIM_C6R: r = PSCC_C6R;
            PSCC_LIM_C7: r = PSCC_C7;
            default: r = PSCC_C7S;
        endcase
        return r;
    endfunction : pscc_limit_state

endpackage : pscc_pkg

// ---- rtl/pscc_io_redirect.sv ----
// pscc_io_redirect: turns I/O reads of the redirect port into wait-for-event requests
// assumes capture base and range come steady from the capture-base register outside
`timescale 1ns/1ns
`default_nettype none
module pscc_io_redirect
    import pscc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // i/o read from the core
    input wire logic io_rd_valid,
    input wire logic [15:0] io_rd_port,
    output logic io_rd_consume,
    // configuration
    input wire logic redirect_en,
    input wire logic [15:0] redirect_port_base,
    input wire logic [2:0] redirect_range,
    // wait-for-event request
    output logic wfe_valid,
    output pscc_cstate_t wfe_state
);

    pscc_redir_t s;
    pscc_redir_t next_s;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    // redirect read on match
    assign io_rd_consume = io_rd_valid && redirect_en && (io_rd_port == redirect_port_base);

    always_comb begin
        next_s = s;
        next_s.wfe_valid = 1'b0;
        if (sys_rst) begin
            next_s = '0;
        end else if (io_rd_consume) begin
            next_s.wfe_valid = 1'b1;
            // range picks deepest state; reserved codes fall back to c3
            case (redirect_range)
                PSCC_RNG_C6: next_s.wfe_state = PSCC_C6R;
                PSCC_RNG_C7: next_s.wfe_state = PSCC_C7;
                default: next_s.wfe_state = PSCC_C3;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        s <= next_s;
    end

    assign wfe_valid = s.wfe_valid;
    assign wfe_state = s.wfe_state;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_redirect_range;
        io_rd_consume && (redirect_range == PSCC_RNG_C6) |=> wfe_valid && (wfe_state == PSCC_C6R);
    endproperty
    a_redirect_range: assert property (p_redirect_range) else $error("range c6 not honoured");

    property p_no_redirect;
        !redirect_en |=> !wfe_valid;
    endproperty
    a_no_redirect: assert property (p_no_redirect) else $error("redirect while disabled");

    c_redirect: cover property (io_rd_consume ##1 wfe_valid);

endmodule : pscc_io_redirect
`default_nettype wire

// ---- rtl/pscc_top.sv ----
// pscc_top: per-core package sleep-state configuration register and demotion control
// assumes msr requests are single-cycle strobes and one instance sits in each core
// Function
// - limit field bits 2:0; 000 allows only c0/c1, 001 caps at c2
// - 010 c6 no retention, 011 c6 retention, 100 c7 deepest
// - 101 c7s deepest, 111 leaves package depth unlimited
// - limit field loads the factory fuse value at reset
// - no limit encoding caps the package at c3
// - bit 10 turns reads of the redirect port into wait-for-event requests
// - bit 15 locks bits 15:0 against writes until next reset
// - bit 25 lets uncore hints demote c6/c7 requests to c3
// - bit 26 lets uncore hints demote c3/c6/c7 requests to c1
// - bit 27 allows undemotion of a request demoted to c3
// - bit 28 allows undemotion of a request demoted to c1
// - redirected reads to the base port are consumed as requests
// - capture range 000 c3, 001 c6, 010 c7 deepest redirected state
`timescale 1ns/1ns
`default_nettype none
module pscc_top
    import pscc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // factory limit
    input wire logic [2:0] fuse_pkg_limit,
    // msr access
    input wire pscc_msr_req_t msr_req,
    output var pscc_msr_rsp_t msr_rsp,
    // core sleep requests
    input wire logic core_req_valid,
    input wire pscc_cstate_t core_req_state,
    // uncore hints
    input wire logic uncore_demote_c3,
    input wire logic uncore_demote_c1,
    input wire logic uncore_undemote,
    // granted core state
    output logic grant_valid,
    output pscc_cstate_t grant_state,
    // package limit
    output pscc_cstate_t pkg_max_state,
    output logic pkg_unlimited,
    // i/o redirection
    input wire logic io_rd_valid,
    input wire logic [15:0] io_rd_port,
    output logic io_rd_consume,
    input wire logic [15:0] redirect_port_base,
    input wire logic [2:0] redirect_range,
    output logic wfe_valid,
    output pscc_cstate_t wfe_state
);

    pscc_state_t s;
    pscc_state_t next_s;
    logic hit;
    logic hit_wr;
    logic deep_c1;
    logic deep_c3;

    assign hit = msr_req.valid && (msr_req.addr == PSCC_CFG_ADDR);
    assign hit_wr = hit && msr_req.write;
    assign deep_c1 = core_req_state >= PSCC_C3;
    assign deep_c3 = core_req_state >= PSCC_C6N;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.rsp.ack = 1'b0;
        next_s.rsp.fault = 1'b0;
        next_s.grant_valid = 1'b0;
        if (sys_rst) begin
            next_s = '0;
            next_s.cfg.pkg_limit = fuse_pkg_limit;
        end else begin
            if (msr_req.valid) begin
                next_s.rsp.ack = 1'b1;
                next_s.rsp.fault = !hit;
                next_s.rsp.rdata = (hit && !msr_req.write) ? pscc_pack(s.cfg) : PSCC_RST_VALUE;
            end
            if (hit_wr) begin
                if (!s.cfg.lock) begin
                    next_s.cfg.pkg_limit = msr_req.wdata[PSCC_LIMIT_MSB:PSCC_LIMIT_LSB];
                    next_s.cfg.io_redirect = msr_req.wdata[PSCC_IOREDIR_BIT];
                    next_s.cfg.lock = msr_req.wdata[PSCC_LOCK_BIT];
                end
                next_s.cfg.c3_autodemote = msr_req.wdata[PSCC_C3AD_BIT];
                next_s.cfg.c1_autodemote = msr_req.wdata[PSCC_C1AD_BIT];
                next_s.cfg.c3_undemote = msr_req.wdata[PSCC_C3UN_BIT];
                next_s.cfg.c1_undemote = msr_req.wdata[PSCC_C1UN_BIT];
            end
            // requests see the settings before this cycle's write
            if (core_req_valid) begin
                next_s.grant_valid = 1'b1;
                next_s.orig = core_req_state;
                next_s.grant_state = core_req_state;
                next_s.phase = (core_req_state == PSCC_C0) ? PSCC_IDLE : PSCC_ACTIVE;
                if (s.cfg.c1_autodemote && uncore_demote_c1 && deep_c1) begin
                    next_s.grant_state = PSCC_C1;
                    next_s.phase = PSCC_DEM_C1;
                end else if (s.cfg.c3_autodemote && uncore_demote_c3 && deep_c3) begin
                    next_s.grant_state = PSCC_C3;
                    next_s.phase = PSCC_DEM_C3;
                end
            end else begin
                case (s.phase)
                    PSCC_DEM_C3: begin
                        if (uncore_undemote && s.cfg.c3_undemote) begin
                            next_s.grant_valid = 1'b1;
                            next_s.grant_state = s.orig;
                            next_s.phase = PSCC_ACTIVE;
                        end
                    end
                    PSCC_DEM_C1: begin
                        if (uncore_undemote && s.cfg.c1_undemote) begin
                            next_s.grant_valid = 1'b1;
                            next_s.grant_state = s.orig;
                            next_s.phase = PSCC_ACTIVE;
                        end
                    end
                    default: begin
                        next_s.phase = s.phase;
                    end
                endcase
            end
        end
        next_s.pkg_max = pscc_limit_state(next_s.cfg.pkg_limit);
        next_s.pkg_unlimited = (next_s.cfg.pkg_limit == PSCC_LIM_NONE);
    end

    always_ff @(posedge mclk) begin
        s <= next_s;
    end

    assign msr_rsp = s.rsp;
    assign grant_valid = s.grant_valid;
    assign grant_state = s.grant_state;
    assign pkg_max_state = s.pkg_max;
    assign pkg_unlimited = s.pkg_unlimited;

    // ----------------------------------------
    // i/o redirection
    // ----------------------------------------
    // enable bit steers the decoder
    pscc_io_redirect u_redir (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .io_rd_valid(io_rd_valid),
        .io_rd_port(io_rd_port),
        .io_rd_consume(io_rd_consume),
        .redirect_en(s.cfg.io_redirect),
        .redirect_port_base(redirect_port_base),
        .redirect_range(redirect_range),
        .wfe_valid(wfe_valid),
        .wfe_state(wfe_state)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_limit_low;
        (s.cfg.pkg_limit == PSCC_LIM_C1) |-> (pkg_max_state == PSCC_C1) && !pkg_unlimited;
    endproperty
    a_limit_low: assert property (p_limit_low) else $error("limit 000 not c1");

    property p_limit_mid;
        (s.cfg.pkg_limit == PSCC_LIM_C7) |-> (pkg_max_state == PSCC_C7);
    endproperty
    a_limit_mid: assert property (p_limit_mid) else $error("limit 100 not c7");

    property p_limit_none;
        (s.cfg.pkg_limit == PSCC_LIM_NONE) |-> pkg_unlimited && (pkg_max_state == PSCC_C7S);
    endproperty
    a_limit_none: assert property (p_limit_none) else $error("limit 111 not unlimited");

    property p_fuse_load;
        $past(sys_rst) |-> (s.cfg.pkg_limit == $past(fuse_pkg_limit)) && !s.cfg.lock;
    endproperty
    a_fuse_load: assert property (p_fuse_load) else $error("fuse limit not loaded");

    property p_never_c3;
        pkg_max_state != PSCC_C3;
    endproperty
    a_never_c3: assert property (p_never_c3) else $error("package capped at c3");

    property p_lock_hold;
        hit_wr && s.cfg.lock |=> $stable({s.cfg.lock, s.cfg.io_redirect, s.cfg.pkg_limit});
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("locked field changed");

    property p_no_demote;
        core_req_valid && !s.cfg.c3_autodemote && !s.cfg.c1_autodemote |=>
            grant_valid && (grant_state == $past(core_req_state));
    endproperty
    a_no_demote: assert property (p_no_demote) else $error("demotion while disabled");

    property p_demote_c1;
        core_req_valid && s.cfg.c1_autodemote && uncore_demote_c1 && deep_c1 |=>
            grant_valid && (grant_state == PSCC_C1) && (s.phase == PSCC_DEM_C1);
    endproperty
    a_demote_c1: assert property (p_demote_c1) else $error("c1 demotion missed");

    property p_undemote_c3;
        !core_req_valid && (s.phase == PSCC_DEM_C3) && uncore_undemote && s.cfg.c3_undemote |=>
            grant_valid && (grant_state == $past(s.orig));
    endproperty
    a_undemote_c3: assert property (p_undemote_c3) else $error("c3 undemotion missed");

    property p_undemote_c1_off;
        !core_req_valid && (s.phase == PSCC_DEM_C1) && !s.cfg.c1_undemote |=> !grant_valid;
    endproperty
    a_undemote_c1_off: assert property (p_undemote_c1_off) else $error("c1 undemoted while disabled");

    property p_rsv_zero;
        msr_rsp.ack |-> ((msr_rsp.rdata & ~PSCC_RD_MASK) == PSCC_RST_VALUE);
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits nonzero");

    c_lock_set: cover property (hit_wr && msr_req.wdata[PSCC_LOCK_BIT] ##1 s.cfg.lock);
    c_demote_c3: cover property (s.phase == PSCC_DEM_C3 ##1 grant_valid);
    c_undemote_c1: cover property (s.phase == PSCC_DEM_C1 ##1 s.phase == PSCC_ACTIVE);

endmodule : pscc_top
`default_nettype wire

// ---- bench/pscc_top_tb.sv ----
// pscc_top_tb: self-checking bench for the package sleep-state config block
// assumes msr answers come on the edge that takes the strobe, one 64-bit word each
`timescale 1ns/1ns
`default_nettype none
module pscc_top_tb
    import pscc_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic mclk;
    logic sys_rst;
    logic [2:0] fuse_pkg_limit;
    pscc_msr_req_t msr_req;
    pscc_msr_rsp_t msr_rsp;
    logic core_req_valid;
    pscc_cstate_t core_req_state;
    logic uncore_demote_c3;
    logic uncore_demote_c1;
    logic uncore_undemote;
    logic grant_valid;
    pscc_cstate_t grant_state;
    pscc_cstate_t pkg_max_state;
    logic pkg_unlimited;
    logic io_rd_valid;
    logic [15:0] io_rd_port;
    logic io_rd_consume;
    logic [15:0] redirect_port_base;
    logic [2:0] redirect_range;
    logic wfe_valid;
    pscc_cstate_t wfe_state;
    int fails;
    int check_count;
    int cycles;
    logic [63:0] rd;
    logic flt;
    // expected decode per limit code; 110 reads like c7s by design choice
    pscc_cstate_t lim_exp [8] = '{PSCC_C1, PSCC_C2, PSCC_C6N, PSCC_C6R, PSCC_C7, PSCC_C7S, PSCC_C7S, PSCC_C7S};
    pscc_cstate_t rng_exp [6] = '{PSCC_C3, PSCC_C6R, PSCC_C7, PSCC_C3, PSCC_C3, PSCC_C3};

    pscc_top dut_u (
        .mclk(mclk), .sys_rst(sys_rst), .fuse_pkg_limit(fuse_pkg_limit),
        .msr_req(msr_req), .msr_rsp(msr_rsp),
        .core_req_valid(core_req_valid), .core_req_state(core_req_state),
        .uncore_demote_c3(uncore_demote_c3), .uncore_demote_c1(uncore_demote_c1),
        .uncore_undemote(uncore_undemote), .grant_valid(grant_valid), .grant_state(grant_state),
        .pkg_max_state(pkg_max_state), .pkg_unlimited(pkg_unlimited),
        .io_rd_valid(io_rd_valid), .io_rd_port(io_rd_port), .io_rd_consume(io_rd_consume),
        .redirect_port_base(redirect_port_base), .redirect_range(redirect_range),
        .wfe_valid(wfe_valid), .wfe_state(wfe_state)
    );

    // ----------------------------------------
    // clock and timeout
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // whole run is about 140 cycles; the ceiling of 3000 leaves wide margin
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            check("timeout", 64'h1, 64'h0);
            end_sim();
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic do_reset(input logic [2:0] fuse);
        @(posedge mclk);
        sys_rst <= 1'b1;
        fuse_pkg_limit <= fuse;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
    endtask : do_reset

    // strobe is one cycle wide; the answer is taken in the ack cycle
    task automatic msr(input logic wr, input logic [31:0] a, input logic [63:0] d);
        @(posedge mclk);
        msr_req <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
        @(posedge mclk);
        msr_req.valid <= 1'b0;
        #1;
        check("msr ack", 64'(msr_rsp.ack), 64'h1);
        rd = msr_rsp.rdata;
        flt = msr_rsp.fault;
    endtask : msr

    task automatic rd_cfg(input logic [63:0] exp);
        msr(1'b0, PSCC_CFG_ADDR, 64'h0);
        check("cfg read", rd, exp);
        check("cfg fault", 64'(flt), 64'h0);
    endtask : rd_cfg

    task automatic hints(input logic c3, input logic c1);
        @(posedge mclk);
        uncore_demote_c3 <= c3;
        uncore_demote_c1 <= c1;
    endtask : hints

    task automatic core_req(input pscc_cstate_t s, input pscc_cstate_t exp);
        @(posedge mclk);
        core_req_valid <= 1'b1;
        core_req_state <= s;
        @(posedge mclk);
        core_req_valid <= 1'b0;
        #1;
        check("grant valid", 64'(grant_valid), 64'h1);
        check("grant state", 64'(grant_state), 64'(exp));
    endtask : core_req

    task automatic undemote(input logic exp_g, input pscc_cstate_t exp);
        int n;
        @(posedge mclk);
        uncore_undemote <= 1'b1;
        for (n = 0; n < 4; n++) begin
            @(posedge mclk);
            #1;
            if (grant_valid === 1'b1) break;
        end
        check("undemote grant", 64'(grant_valid), 64'(exp_g));
        if (exp_g) check("undemote state", 64'(grant_state), 64'(exp));
        @(posedge mclk);
        uncore_undemote <= 1'b0;
    endtask : undemote

    task automatic io_read(input logic [15:0] port, input logic exp_take, input pscc_cstate_t exp);
        @(posedge mclk);
        io_rd_valid <= 1'b1;
        io_rd_port <= port;
        #1;
        check("io consume", 64'(io_rd_consume), 64'(exp_take));
        @(posedge mclk);
        io_rd_valid <= 1'b0;
        #1;
        check("wfe valid", 64'(wfe_valid), 64'(exp_take));
        if (exp_take) check("wfe state", 64'(wfe_state), 64'(exp));
    endtask : io_read

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        sys_rst = 1'b1;
        fuse_pkg_limit = 3'h3;
        msr_req = '0;
        core_req_valid = 1'b0;
        core_req_state = PSCC_C0;
        uncore_demote_c3 = 1'b0;
        uncore_demote_c1 = 1'b0;
        uncore_undemote = 1'b0;
        io_rd_valid = 1'b0;
        io_rd_port = 16'h0000;
        redirect_port_base = 16'h0400;
        redirect_range = 3'h0;
        fails = 0;
        check_count = 0;
        cycles = 0;
        do_reset(3'h3);
        rd_cfg(64'h0000000000000003);
        check("pkg max", 64'(pkg_max_state), 64'(PSCC_C6R));
        for (int k = 0; k < 8; k++) begin
            msr(1'b1, PSCC_CFG_ADDR, 64'(k));
            rd_cfg(64'(k));
            check("pkg max", 64'(pkg_max_state), 64'(lim_exp[k]));
            check("pkg unlimited", 64'(pkg_unlimited), 64'(k == 7));
            check("no c3 cap", 64'(pkg_max_state == PSCC_C3), 64'h0);
        end
        msr(1'b1, PSCC_CFG_ADDR, 64'hFFFFFFFFFFFF7FFF);
        rd_cfg(64'h000000001E000407);
        msr(1'b1, 32'h000000E4, 64'h0);
        check("unmapped fault", 64'(flt), 64'h1);
        msr(1'b0, 32'h000000E4, 64'h0);
        check("unmapped rdata", rd, 64'h0);
        rd_cfg(64'h000000001E000407);
        for (int r = 0; r < 6; r++) begin
            @(posedge mclk);
            redirect_range <= 3'(r);
            io_read(16'h0400, 1'b1, rng_exp[r]);
        end
        io_read(16'h0401, 1'b0, PSCC_C3);
        msr(1'b1, PSCC_CFG_ADDR, 64'h000000001E000007);
        io_read(16'h0400, 1'b0, PSCC_C3);
        hints(1'b1, 1'b0);
        core_req(PSCC_C7, PSCC_C3);
        hints(1'b0, 1'b0);
        undemote(1'b1, PSCC_C7);
        hints(1'b0, 1'b1);
        core_req(PSCC_C6N, PSCC_C1);
        core_req(PSCC_C2, PSCC_C2);
        core_req(PSCC_C3, PSCC_C1);
        hints(1'b0, 1'b0);
        undemote(1'b1, PSCC_C3);
        // settings change applies to the next request
        msr(1'b1, PSCC_CFG_ADDR, 64'h0000000002000007);
        hints(1'b1, 1'b1);
        core_req(PSCC_C7, PSCC_C3);
        hints(1'b0, 1'b0);
        undemote(1'b0, PSCC_C3);
        msr(1'b1, PSCC_CFG_ADDR, 64'h0000000000000007);
        hints(1'b1, 1'b1);
        core_req(PSCC_C6R, PSCC_C6R);
        hints(1'b0, 1'b0);
        // c1 demotion with its undemotion left off
        msr(1'b1, PSCC_CFG_ADDR, 64'h0000000004000007);
        hints(1'b1, 1'b1);
        core_req(PSCC_C7, PSCC_C1);
        hints(1'b0, 1'b0);
        undemote(1'b0, PSCC_C1);
        // lock holds low half, high enables stay writable
        msr(1'b1, PSCC_CFG_ADDR, 64'h0000000000008402);
        msr(1'b1, PSCC_CFG_ADDR, 64'h0000000002000005);
        rd_cfg(64'h0000000002008402);
        check("pkg max locked", 64'(pkg_max_state), 64'(PSCC_C6N));
        do_reset(3'h5);
        rd_cfg(64'h0000000000000005);
        msr(1'b1, PSCC_CFG_ADDR, 64'h0000000000000001);
        rd_cfg(64'h0000000000000001);
        end_sim();
    end

endmodule : pscc_top_tb
`default_nettype wire
